// File: design/supervisor_params.svh
// timing constants, reset values and the summary of operation for the supervisor
// Summary of operation
// - manual reset low holds reset, then reset stays at least the hold time after release.
// - any kick edge of at least 100ns restarts the watchdog; processor must toggle it.
// - kick static longer than the watchdog period fires a reset pulse of hold time.
// - watchdog timer clears whenever reset is asserted from any source.
// - a kick that stays static yields a reset pulse after every watchdog period.
// - backup mode only when main is below trip level and below the battery.
// - battery flag high in backup mode, low when main exceeds the battery.
// - backup mode holds reset, switches output to battery, ignores other inputs.
// - at startup the switched output comes from main, never from battery alone.
// - auxiliary sense below the 1.235V reference asserts reset.
// - reset stays while auxiliary sense is low and hold time after it rises.
// - reset while main below trip level and hold time after it recovers.
// - reset polarity fixed per variant; output always drives a defined level.
// - main feeds output when above trip level, otherwise the greater supply.
// - battery changes while main is good cause no backup entry and no reset.
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define RESET_HOLD_MS 150
`define RESET_HOLD_CYCLES (`RESET_HOLD_MS * 1000000 / `CLK_PERIOD_NS)
`define WATCHDOG_PERIOD_MS 1600
`define WATCHDOG_CYCLES (`WATCHDOG_PERIOD_MS * 1000000 / `CLK_PERIOD_NS)
`define KICK_MIN_NS 100
`define KICK_MIN_CYCLES ((`KICK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 32
`define SEL_MAIN 1'b0
`define SEL_BACKUP_BATTERY_IN 1'b1
`endif

// File: design/supervisor_pkg.sv
// types shared by the supervisor
package supervisor_pkg;
  typedef enum logic [2:0] {
    ST_STARTUP = 3'b001,
    ST_NORMAL = 3'b010,
    ST_BACKUP = 3'b100
  } power_state_e;
endpackage

// File: design/supervisor_reset_watchdog_backup.sv
// supervisor: reset generation, watchdog and battery backup switchover
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_params.svh"
module supervisor_reset_watchdog_backup #(
  parameter int unsigned RESET_HOLD_CYCLES = `RESET_HOLD_CYCLES,
  parameter int unsigned WATCHDOG_CYCLES = `WATCHDOG_CYCLES,
  parameter int unsigned KICK_MIN_CYCLES = `KICK_MIN_CYCLES,
  parameter bit RESET_ACTIVE_HIGH = 1'b0
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic main_below_trip_i,
  input wire logic main_below_backup_battery_in_i,
  input wire logic aux_sense_low_i,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  output logic reset_o,
  output logic supply_sel_o,
  output logic main_switch_on_o,
  output logic backup_battery_in_switch_on_o,
  output logic battery_mode_flag
);
  // ****************************************
  // reset release
  // ****************************************
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ****************************************
  // input conditioning
  // ****************************************
  logic mr_level;
  logic kick_edge;
  sync_edge #(.MIN_CYCLES(1)) u_mr (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(manual_reset_n),
    .level_o(mr_level),
    .edge_o()
  );
  sync_edge #(.MIN_CYCLES(KICK_MIN_CYCLES)) u_kick (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(watchdog_kick_in),
    .level_o(),
    .edge_o(kick_edge)
  );

  // ****************************************
  // power state
  // ****************************************
  supervisor_pkg::power_state_e state;
  supervisor_pkg::power_state_e next_state;
  always_comb
  begin
    next_state = state;
    case (state)
      supervisor_pkg::ST_STARTUP:
      begin
        if (!main_below_trip_i)
        begin
          next_state = supervisor_pkg::ST_NORMAL;
        end
      end
      supervisor_pkg::ST_NORMAL:
      begin
        // both conditions; battery alone never enters
        if (main_below_trip_i && main_below_backup_battery_in_i)
        begin
          next_state = supervisor_pkg::ST_BACKUP;
        end
      end
      supervisor_pkg::ST_BACKUP:
      begin
        // leave when main exceeds battery or recovers
        if (!main_below_backup_battery_in_i || !main_below_trip_i)
        begin
          next_state = supervisor_pkg::ST_NORMAL;
        end
      end
      default:
      begin
        next_state = supervisor_pkg::ST_STARTUP;
      end
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= supervisor_pkg::ST_STARTUP;
    end
    else
    begin
      state <= next_state;
    end
  end
  logic in_backup;
  assign in_backup = (state == supervisor_pkg::ST_BACKUP);

  // ****************************************
  // reset sources and hold timer
  // ****************************************
  logic wd_fire;
  logic level_cause;
  // inputs ignored in backup; level causes
  assign level_cause = in_backup || main_below_trip_i || (state == supervisor_pkg::ST_STARTUP)
    || (!in_backup && (aux_sense_low_i || !mr_level));

  logic [`CNT_W-1:0] hold_cnt;
  logic [`CNT_W-1:0] next_hold_cnt;
  logic rst_active;
  logic next_rst_active;
  always_comb
  begin
    next_hold_cnt = hold_cnt;
    next_rst_active = rst_active;
    if (level_cause || wd_fire)
    begin
      next_hold_cnt = `CNT_W'(RESET_HOLD_CYCLES);
      next_rst_active = 1'b1;
    end
    else if (hold_cnt > `CNT_W'(1))
    begin
      next_hold_cnt = hold_cnt - `CNT_W'(1);
    end
    else
    begin
      next_hold_cnt = '0;
      next_rst_active = 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_cnt <= '0;
      rst_active <= 1'b1;
    end
    else
    begin
      hold_cnt <= next_hold_cnt;
      rst_active <= next_rst_active;
    end
  end

  // ****************************************
  // watchdog
  // ****************************************
  logic [`CNT_W-1:0] wd_cnt;
  logic [`CNT_W-1:0] next_wd_cnt;
  always_comb
  begin
    next_wd_cnt = wd_cnt + `CNT_W'(1);
    // clear while reset asserts; clear on kick
    if (rst_active || next_rst_active || kick_edge)
    begin
      next_wd_cnt = '0;
    end
  end
  assign wd_fire = !rst_active && !in_backup && (wd_cnt >= `CNT_W'(WATCHDOG_CYCLES - 1));
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wd_cnt <= '0;
    end
    else
    begin
      wd_cnt <= next_wd_cnt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic rst_out;
  logic sel;
  logic flag;
  logic next_sel;
  logic next_flag;
  always_comb
  begin
    // main when good, else greater; battery in backup
    next_sel = (next_state == supervisor_pkg::ST_BACKUP) ? `SEL_BACKUP_BATTERY_IN : `SEL_MAIN;
    next_flag = (next_state == supervisor_pkg::ST_BACKUP);
  end
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_out <= 1'b1;
      sel <= `SEL_MAIN;
      flag <= 1'b0;
    end
    else
    begin
      rst_out <= next_rst_active;
      sel <= next_sel;
      flag <= next_flag;
    end
  end
  assign reset_o = RESET_ACTIVE_HIGH ? rst_out : !rst_out;
  assign supply_sel_o = sel;
  assign main_switch_on_o = (sel == `SEL_MAIN);
  assign backup_battery_in_switch_on_o = (sel == `SEL_BACKUP_BATTERY_IN);
  assign battery_mode_flag = flag;

  // ****************************************
  // checks
  // ****************************************
  property p_backup_holds_reset;
    @(posedge clk_i) disable iff (!rst_n) in_backup |-> rst_out && backup_battery_in_switch_on_o;
  endproperty
  a_backup_holds_reset: assert property (p_backup_holds_reset) else $error("backup without reset");
  property p_flag_low_main_high;
    @(posedge clk_i) disable iff (!rst_n) (!main_below_backup_battery_in_i && state != supervisor_pkg::ST_STARTUP)
      |=> !battery_mode_flag;
  endproperty
  a_flag_low_main_high: assert property (p_flag_low_main_high) else $error("flag high with main good");
  property p_no_backup_main_good;
    @(posedge clk_i) disable iff (!rst_n) !main_below_trip_i |=> !in_backup;
  endproperty
  a_no_backup_main_good: assert property (p_no_backup_main_good) else $error("backup while main good");
  property p_startup_main;
    @(posedge clk_i) disable iff (!rst_n) state == supervisor_pkg::ST_STARTUP |-> !backup_battery_in_switch_on_o;
  endproperty
  a_startup_main: assert property (p_startup_main) else $error("battery used at startup");
  property p_aux_reset;
    @(posedge clk_i) disable iff (!rst_n) (aux_sense_low_i && !in_backup) |=> rst_out;
  endproperty
  a_aux_reset: assert property (p_aux_reset) else $error("aux low without reset");
  property p_main_reset;
    @(posedge clk_i) disable iff (!rst_n) main_below_trip_i |=> rst_out;
  endproperty
  a_main_reset: assert property (p_main_reset) else $error("main low without reset");
  property p_wd_clear;
    @(posedge clk_i) disable iff (!rst_n) rst_active |=> wd_cnt == '0;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog not cleared by reset");
  property p_hold_min;
    @(posedge clk_i) disable iff (!rst_n) $fell(level_cause) |=> rst_out [*2];
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("reset released early");
  property p_wd_fire;
    @(posedge clk_i) disable iff (!rst_n) wd_fire |=> rst_out && wd_cnt == '0;
  endproperty
  a_wd_fire: assert property (p_wd_fire) else $error("timeout gave no reset");
  property p_mr_reset;
    @(posedge clk_i) disable iff (!rst_n) (!mr_level && !in_backup) |=> rst_out;
  endproperty
  a_mr_reset: assert property (p_mr_reset) else $error("manual reset low without reset");
  property p_aux_hold;
    @(posedge clk_i) disable iff (!rst_n) ($fell(aux_sense_low_i) && !in_backup) |=> rst_out [*2];
  endproperty
  a_aux_hold: assert property (p_aux_hold) else $error("reset dropped as aux rose");
  property p_backup_entry;
    @(posedge clk_i) disable iff (!rst_n)
      (state == supervisor_pkg::ST_NORMAL && main_below_trip_i && main_below_backup_battery_in_i)
      |=> in_backup && battery_mode_flag;
  endproperty
  a_backup_entry: assert property (p_backup_entry) else $error("backup not entered");
  property p_backup_needs_both;
    @(posedge clk_i) disable iff (!rst_n) (!in_backup && !(main_below_trip_i && main_below_backup_battery_in_i)) |=> !in_backup;
  endproperty
  a_backup_needs_both: assert property (p_backup_needs_both) else $error("backup entered on one condition");
  property p_backup_exit;
    @(posedge clk_i) disable iff (!rst_n) (in_backup && !main_below_trip_i)
      |=> main_switch_on_o && !battery_mode_flag;
  endproperty
  a_backup_exit: assert property (p_backup_exit) else $error("main good but battery selected");
  property p_kick_clear;
    @(posedge clk_i) disable iff (!rst_n) kick_edge |=> wd_cnt == '0;
  endproperty
  a_kick_clear: assert property (p_kick_clear) else $error("kick did not clear watchdog");
  property p_wd_bound;
    @(posedge clk_i) disable iff (!rst_n) !rst_active |-> wd_cnt < `CNT_W'(WATCHDOG_CYCLES);
  endproperty
  a_wd_bound: assert property (p_wd_bound) else $error("watchdog ran past its period");
  property p_release_count;
    @(posedge clk_i) disable iff (!rst_n) $fell(rst_active) |-> $past(hold_cnt) == `CNT_W'(1);
  endproperty
  a_release_count: assert property (p_release_count) else $error("reset released before hold ran out");
endmodule
`default_nettype wire

// File: design/sync_edge.sv
// two-flop synchroniser with a filtered level and edge pulse
`timescale 1ns/1ps
`default_nettype none
module sync_edge #(
  parameter int unsigned MIN_CYCLES = 10
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic level_o,
  output logic edge_o
);
  logic s1;
  logic s2;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_level;
  logic lvl;

  always_comb
  begin
    next_cnt = 8'h00;
    next_level = lvl;
    if (s2 != lvl)
    begin
      next_cnt = cnt + 8'h01;
      if (cnt + 8'h01 >= 8'(MIN_CYCLES))
      begin
        next_level = s2;
        next_cnt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      cnt <= 8'h00;
      lvl <= 1'b1;
    end
    else
    begin
      s1 <= d_i;
      s2 <= s1;
      cnt <= next_cnt;
      lvl <= next_level;
    end
  end

  assign level_o = lvl;
  assign edge_o = (next_level != lvl);
endmodule
`default_nettype wire

// File: test/cpu_model.sv
// processor model that takes the reset and toggles the watchdog kick
`timescale 1ns/1ps
`default_nettype none
module cpu_model #(
  parameter int unsigned KICK_GAP = 20
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic stall_i,
  input wire logic glitch_i,
  output logic kick_o
);
  int unsigned cnt = 0;
  logic kick_q = 1'b0;
  always @(posedge clk_i)
  begin
    if (reset_n_i === 1'b1 && !stall_i)
    begin
      cnt <= (cnt == KICK_GAP - 1) ? 0 : cnt + 1;
      if (cnt == KICK_GAP - 1)
        kick_q <= ~kick_q;
    end
  end
  // glitch_i flips the pin for as long as the bench holds it
  assign kick_o = kick_q ^ glitch_i;
endmodule
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned HOLD = 20;
  localparam int unsigned WDOG = 50;
  // reset, sel, main switch, battery switch, flag
  localparam logic [4:0] RUN_ST = 5'h14;
  localparam logic [4:0] HOLD_ST = 5'h04;
  localparam logic [4:0] BAK_ST = 5'h0b;
  logic clk;
  logic arst_n;
  logic main_trip;
  logic main_backup_battery_in;
  logic aux_low;
  logic mr_n;
  logic stall;
  logic glitch;
  logic kick;
  logic rst_out;
  logic sel;
  logic msw;
  logic bsw;
  logic flag;
  logic [4:0] exp_q[$];
  int bad_count;
  int total_checks;
  supervisor_reset_watchdog_backup #(.RESET_HOLD_CYCLES(HOLD), .WATCHDOG_CYCLES(WDOG), .KICK_MIN_CYCLES(10))
    i_supervisor_reset_watchdog_backup (.clk_i(clk), .arst_n_i(arst_n), .main_below_trip_i(main_trip),
    .main_below_backup_battery_in_i(main_backup_battery_in), .aux_sense_low_i(aux_low), .manual_reset_n(mr_n), .watchdog_kick_in(kick),
    .reset_o(rst_out), .supply_sel_o(sel), .main_switch_on_o(msw), .backup_battery_in_switch_on_o(bsw),
    .battery_mode_flag(flag));
  cpu_model i_cpu_model (.clk_i(clk), .reset_n_i(rst_out), .stall_i(stall), .glitch_i(glitch), .kick_o(kick));
  // ***********
  // helpers
  // ***********
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic note(input logic [4:0] e);
    @(posedge clk);
    exp_q.push_back(e);
  endtask
  task automatic cmp(input logic [4:0] e, input logic [4:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic span(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (rst_out !== lvl && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    total_checks++;
    if (n < lo || n > hi)
    begin
      bad_count++;
      $display("mismatch at %0t span %h exp %h..%h", $time, n, lo, hi);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(negedge clk)
    while (exp_q.size() > 0)
      cmp(exp_q.pop_front(), {rst_out, sel, msw, bsw, flag});
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    cyc(3000);
    bad_count++;
    complete_run();
  end
  // ***********
  // tests
  // ***********
  initial
  begin
    arst_n = 1'b0;
    main_trip = 1'b1;
    main_backup_battery_in = 1'b1;
    aux_low = 1'b0;
    mr_n = 1'b1;
    stall = 1'b0;
    glitch = 1'b0;
    bad_count = 0;
    total_checks = 0;
    void'($urandom(32'h81c6));
    cyc(8);
    arst_n <= 1'b1;
    cyc(15);
    note(HOLD_ST);
    main_trip <= 1'b0;
    main_backup_battery_in <= 1'b0;
    cyc(HOLD - 5);
    note(HOLD_ST);
    cyc(20);
    note(RUN_ST);
    $display("test startup done");
    mr_n <= 1'b0;
    cyc(15 + $urandom_range(20));
    note(HOLD_ST);
    mr_n <= 1'b1;
    cyc(HOLD);
    note(HOLD_ST);
    cyc(20);
    note(RUN_ST);
    $display("test manual done");
    aux_low <= 1'b1;
    cyc(2);
    note(HOLD_ST);
    aux_low <= 1'b0;
    cyc(HOLD - 3);
    note(HOLD_ST);
    cyc(10);
    note(RUN_ST);
    $display("test aux done");
    stall <= 1'b1;
    span(1'b0, WDOG - 20, WDOG + 20);
    span(1'b1, HOLD - 1, HOLD + 2);
    @(posedge clk);
    glitch <= 1'b1;
    cyc(3);
    glitch <= 1'b0;
    span(1'b0, WDOG - 6, WDOG);
    span(1'b1, HOLD - 1, HOLD + 2);
    @(posedge clk);
    stall <= 1'b0;
    cyc(80);
    note(RUN_ST);
    $display("test watchdog done");
    main_trip <= 1'b1;
    cyc(2);
    note(HOLD_ST);
    main_backup_battery_in <= 1'b1;
    cyc(2);
    note(BAK_ST);
    mr_n <= 1'b0;
    aux_low <= 1'b1;
    cyc(20);
    note(BAK_ST);
    mr_n <= 1'b1;
    aux_low <= 1'b0;
    main_backup_battery_in <= 1'b0;
    cyc(2);
    note(HOLD_ST);
    main_trip <= 1'b0;
    cyc(HOLD + 20);
    note(RUN_ST);
    repeat (4)
    begin
      main_backup_battery_in <= 1'($urandom);
      cyc(5);
      note(RUN_ST);
    end
    $display("test backup done");
    cyc(2);
    complete_run();
  end
endmodule
`default_nettype wire
